// File: common/php_if.sv
// pins of the parallel host register port between processor and device
`timescale 1ns/1ps
interface php_if;
    logic       port_select_n;
    logic       port_read_strobe_n;
    logic       port_write_strobe_n;
    logic       register_select;
    logic [7:0] host_data;
    logic       host_data_oe_n;
    logic [7:0] dev_data;
    logic       dev_data_oe_n;
    wire  [7:0] port_data_bus;

    // ======================================================
    // resolved shared bus, floats high when nobody drives
    assign port_data_bus = !host_data_oe_n ? host_data :
                           !dev_data_oe_n  ? dev_data  : 8'hFF;

    modport device (
        input  port_select_n,
        input  port_read_strobe_n,
        input  port_write_strobe_n,
        input  register_select,
        input  port_data_bus,
        output dev_data,
        output dev_data_oe_n
    );

    modport host (
        output port_select_n,
        output port_read_strobe_n,
        output port_write_strobe_n,
        output register_select,
        output host_data,
        output host_data_oe_n,
        input  port_data_bus
    );
endinterface

// File: common/php_pkg.sv
// shared constants for the parallel host register port
package php_pkg;
    // ======================================================
    // clock and bus geometry
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          DATA_W        = 8;
    localparam int          REG_ADDR_W    = 8;

    // ======================================================
    // register-select line levels
    localparam logic        SEL_ADDR      = 1'b1;
    localparam logic        SEL_DATA      = 1'b0;

    // ======================================================
    // reset values
    localparam logic [7:0]  ADDR_RESET    = 8'h00;
    localparam logic [7:0]  DATA_RESET    = 8'h00;

    // ======================================================
    // port timing, in nanoseconds as printed
    localparam int          TSU_ADDR_NS   = 10;
    localparam int          TPW_STROBE_NS = 60;
    localparam int          TH_DATA_NS    = 60;
    localparam int          TACC_MAX_NS   = 35;

    // least times round up, longest times round down, never under one cycle
    localparam int          TSU_ADDR_CYC  = (TSU_ADDR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TPW_STROBE_CYC = (TPW_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TH_DATA_CYC   = (TH_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TACC_RAW_CYC  = TACC_MAX_NS / CLK_PERIOD_NS;
    localparam int          TACC_CYC      = (TACC_RAW_CYC < 1) ? 1 : TACC_RAW_CYC;

    // ======================================================
    // bus styles
    typedef enum logic {
        PHP_STYLE_STROBE = 1'b0,
        PHP_STYLE_SELECT = 1'b1
    } php_style_t;
endpackage

// File: hw/php_device.sv
// device end: decodes port accesses into an address register and host register strobes
`timescale 1ns/1ps
//
// Contract
// (RULE1) select low addresses device, high ignores all
// (RULE2) read strobe low requests register data
// (RULE3) write strobe low delivers a byte
// (RULE4) register select high address, low data
// (RULE5) eight-bit bidirectional data bus
// (RULE6) address and data share one bus
// (RULE7) drive only when selected, reading, not writing; the device enable lags this decode by one clock
// (RULE8) separate-strobe or select-strobed timing both work
// (RULE9) address register picks host register for data
module php_device #(
    parameter int DATA_W = php_pkg::DATA_W
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // port pins
    php_if.device           bus,
    // host register side
    input  wire logic [7:0] rd_data_in,
    output logic [7:0]      reg_addr_out,
    output logic            rd_strobe_out,
    output logic            wr_strobe_out,
    output logic [7:0]      wr_data_out,
    // status
    output logic            busy_out,
    output logic            conflict_out
);
    initial begin
        if (DATA_W != 8)
            $error("php_device: only an eight-bit data bus is supported");
    end

    typedef enum logic [2:0] {
        PHP_D_IDLE  = 3'b001,
        PHP_D_READ  = 3'b010,
        PHP_D_WRITE = 3'b100
    } php_dstate_t;

    // ======================================================
    // access decode from the pins
    logic selected;
    logic rd_act;
    logic wr_act;

    // select gates everything; with select-strobed timing the strobes
    // are steady direction levels and select itself opens and closes the access
    assign selected = !bus.port_select_n;                             // [RULE1] [RULE8]
    assign rd_act   = selected && !bus.port_read_strobe_n
                      && bus.port_write_strobe_n;                     // [RULE2] [RULE7]
    assign wr_act   = selected && !bus.port_write_strobe_n
                      && bus.port_read_strobe_n;                      // [RULE3]

    php_dstate_t state_q;
    logic        sel_q;
    logic [7:0]  wdata_q;
    logic [7:0]  addr_q;

    // ======================================================
    // access state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= PHP_D_IDLE;
        end else begin
            unique case (state_q)
                PHP_D_IDLE: begin
                    if (rd_act)
                        state_q <= PHP_D_READ;
                    else if (wr_act)
                        state_q <= PHP_D_WRITE;
                end
                PHP_D_READ: begin
                    if (!rd_act)
                        state_q <= PHP_D_IDLE;
                end
                PHP_D_WRITE: begin
                    if (!wr_act)
                        state_q <= PHP_D_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // write capture: data and select follow the bus while the
    // write is open, the last values are committed when it closes
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wdata_q <= php_pkg::DATA_RESET;
            sel_q   <= php_pkg::SEL_DATA;
        end else if (wr_act) begin
            wdata_q <= bus.port_data_bus;                             // [RULE5] [RULE6]
            sel_q   <= bus.register_select;                           // [RULE4]
        end else if (rd_act && state_q == PHP_D_IDLE) begin
            sel_q   <= bus.register_select;                           // [RULE4]
        end
    end

    logic commit;
    assign commit = (state_q == PHP_D_WRITE) && !wr_act;

    // ======================================================
    // address register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            addr_q <= php_pkg::ADDR_RESET;
        end else if (commit && sel_q == php_pkg::SEL_ADDR) begin
            addr_q <= wdata_q;                                        // [RULE9]
        end
    end

    // ======================================================
    // host register strobes
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_addr_out  <= php_pkg::ADDR_RESET;
            rd_strobe_out <= 1'b0;
            wr_strobe_out <= 1'b0;
            wr_data_out   <= php_pkg::DATA_RESET;
        end else begin
            reg_addr_out  <= (commit && sel_q == php_pkg::SEL_ADDR) ? wdata_q : addr_q;
            rd_strobe_out <= 1'b0;
            wr_strobe_out <= 1'b0;
            if (commit && sel_q == php_pkg::SEL_DATA) begin
                wr_strobe_out <= 1'b1;                                // [RULE9]
                wr_data_out   <= wdata_q;
            end
            if (state_q == PHP_D_IDLE && rd_act
                && bus.register_select == php_pkg::SEL_DATA) begin
                rd_strobe_out <= 1'b1;                                // [RULE9]
            end
        end
    end

    // ======================================================
    // read drivers: enable is active low, follows the decode one clock later
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bus.dev_data_oe_n <= 1'b1;
            bus.dev_data      <= php_pkg::DATA_RESET;
        end else begin
            bus.dev_data_oe_n <= !rd_act;                             // [RULE7]
            bus.dev_data      <= (bus.register_select == php_pkg::SEL_ADDR)
                                 ? addr_q : rd_data_in;               // [RULE4] [RULE6]
        end
    end

    // ======================================================
    // status
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy_out     <= 1'b0;
            conflict_out <= 1'b0;
        end else begin
            busy_out     <= rd_act || wr_act;
            // both strobes low while selected is no legal access and is ignored
            conflict_out <= selected && !bus.port_read_strobe_n
                            && !bus.port_write_strobe_n;
        end
    end
endmodule

// File: hw/php_host.sv
// processor end: turns user requests into strobed port accesses
`timescale 1ns/1ps
module php_host #(
    parameter php_pkg::php_style_t STYLE = php_pkg::PHP_STYLE_STROBE
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // port pins
    php_if.host             bus,
    // user request
    input  wire logic       req_valid_in,
    input  wire logic       req_write_in,
    input  wire logic       req_sel_in,
    input  wire logic [7:0] req_data_in,
    output logic            req_ready_out,
    // user answer
    output logic            rsp_valid_out,
    output logic [7:0]      rsp_data_out
);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(php_pkg::TSU_ADDR_CYC - 1);
    localparam logic [CNT_W-1:0] PW_LAST    = CNT_W'(php_pkg::TPW_STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST  = CNT_W'(php_pkg::TH_DATA_CYC - 1);

    initial begin
        if (php_pkg::TPW_STROBE_CYC > 15 || php_pkg::TH_DATA_CYC > 15)
            $error("php_host: timing counts exceed counter width");
        if (php_pkg::TPW_STROBE_CYC <= php_pkg::TACC_CYC + 1)
            $error("php_host: strobe too short for read access");
    end

    typedef enum logic [3:0] {
        PHP_IDLE   = 4'b0001,
        PHP_SETUP  = 4'b0010,
        PHP_STROBE = 4'b0100,
        PHP_HOLD   = 4'b1000
    } php_hstate_t;

    php_hstate_t      state_q;
    logic [CNT_W-1:0] cnt_q;
    logic             write_q;

    // ======================================================
    // sequencer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= PHP_IDLE;
            cnt_q   <= '0;
        end else begin
            unique case (state_q)
                PHP_IDLE: begin
                    cnt_q <= '0;
                    if (req_valid_in)
                        state_q <= PHP_SETUP;
                end
                PHP_SETUP: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == SETUP_LAST) begin
                        state_q <= PHP_STROBE;
                        cnt_q   <= '0;
                    end
                end
                PHP_STROBE: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == PW_LAST) begin
                        state_q <= PHP_HOLD;
                        cnt_q   <= '0;
                    end
                end
                PHP_HOLD: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == HOLD_LAST) begin
                        state_q <= PHP_IDLE;
                        cnt_q   <= '0;
                    end
                end
            endcase
        end
    end

    // ======================================================
    // pins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bus.port_select_n       <= 1'b1;
            bus.port_read_strobe_n  <= 1'b1;
            bus.port_write_strobe_n <= 1'b1;
            bus.register_select     <= 1'b0;
            bus.host_data           <= 8'h00;
            bus.host_data_oe_n      <= 1'b1;
            write_q                 <= 1'b0;
        end else if (state_q == PHP_IDLE && req_valid_in) begin
            write_q                 <= req_write_in;
            bus.register_select     <= req_sel_in;               // [RULE4]
            bus.host_data           <= req_data_in;
            bus.host_data_oe_n      <= !req_write_in;
            if (STYLE == php_pkg::PHP_STYLE_STROBE) begin
                bus.port_select_n   <= 1'b0;                     // [RULE1] [RULE8]
            end else begin
                bus.port_read_strobe_n  <= req_write_in;         // [RULE8]
                bus.port_write_strobe_n <= !req_write_in;
            end
        end else if (state_q == PHP_SETUP && cnt_q == SETUP_LAST) begin
            if (STYLE == php_pkg::PHP_STYLE_STROBE) begin
                bus.port_read_strobe_n  <= write_q;              // [RULE2]
                bus.port_write_strobe_n <= !write_q;             // [RULE3]
            end else begin
                bus.port_select_n       <= 1'b0;                 // [RULE1]
            end
        end else if (state_q == PHP_STROBE && cnt_q == PW_LAST) begin
            if (STYLE == php_pkg::PHP_STYLE_STROBE) begin
                bus.port_read_strobe_n  <= 1'b1;
                bus.port_write_strobe_n <= 1'b1;
            end else begin
                bus.port_select_n       <= 1'b1;
            end
        end else if (state_q == PHP_HOLD && cnt_q == HOLD_LAST) begin
            bus.port_select_n       <= 1'b1;
            bus.port_read_strobe_n  <= 1'b1;
            bus.port_write_strobe_n <= 1'b1;
            bus.host_data_oe_n      <= 1'b1;
        end
    end

    // ======================================================
    // user handshake and read capture
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= 8'h00;
        end else begin
            req_ready_out <= (state_q == PHP_HOLD && cnt_q == HOLD_LAST);
            rsp_valid_out <= 1'b0;
            if (state_q == PHP_STROBE && cnt_q == PW_LAST && !write_q) begin
                rsp_valid_out <= 1'b1;
                rsp_data_out  <= bus.port_data_bus;
            end
        end
    end
endmodule

// File: verif/php_port_checker.sv
// concurrent checks on the port pins joining processor and device ends
`timescale 1ns/1ps
module php_port_checker (
    // clock and reset
    input wire logic       clk_in,
    input wire logic       rst_in,
    // port pins
    input wire logic       port_select_n,
    input wire logic       port_read_strobe_n,
    input wire logic       port_write_strobe_n,
    input wire logic       register_select,
    input wire logic [7:0] host_data,
    input wire logic       host_data_oe_n,
    input wire logic [7:0] dev_data,
    input wire logic       dev_data_oe_n,
    input wire logic [7:0] port_data_bus
);
    // ======================================================
    // helpers
    logic rd_open;
    assign rd_open = !port_select_n && !port_read_strobe_n && port_write_strobe_n;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // ======================================================
    // properties
    property p_oe_cause; !dev_data_oe_n |-> $past(rd_open); endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("device drives bus without a read access");
    property p_oe_on; rd_open[*2] |-> !dev_data_oe_n; endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("device silent during read access");
    property p_idle_hiz; port_select_n[*2] |-> dev_data_oe_n; endproperty
    a_idle_hiz: assert property (p_idle_hiz)
        else $error("device drives bus while not selected");
    property p_no_fight; !(!host_data_oe_n && !dev_data_oe_n); endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("both ends drive the data bus");
    property p_rd_data; !dev_data_oe_n |-> port_data_bus == dev_data; endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("bus does not carry device byte");
    property p_rs_stable; !port_select_n && $past(!port_select_n) |-> $stable(register_select);
    endproperty
    a_rs_stable: assert property (p_rs_stable)
        else $error("register select moved inside an access");
    property p_wr_data;
        !port_select_n && !port_write_strobe_n |-> !host_data_oe_n && $stable(host_data);
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("write byte not held under write strobe");
    property p_wr_width; $fell(port_write_strobe_n) |-> !port_write_strobe_n[*3]; endproperty
    a_wr_width: assert property (p_wr_width)
        else $error("write strobe shorter than three cycles");
    property p_rd_width; $fell(port_read_strobe_n) |-> !port_read_strobe_n[*3]; endproperty
    a_rd_width: assert property (p_rd_width)
        else $error("read strobe shorter than three cycles");
    property p_sel_frame;
        port_select_n |-> port_read_strobe_n && port_write_strobe_n;
    endproperty
    a_sel_frame: assert property (p_sel_frame)
        else $error("strobe active outside select frame");
endmodule

// File: verif/tb.sv
// self-checking bench for both ends of the parallel host register port
`timescale 1ns/1ps
module tb;
    // ======================================================
    // clock, reset and wiring
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       req_valid = 1'b0;
    logic       req_write = 1'b0;
    logic       req_sel = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic       req_ready;
    logic [7:0] rsp_data, addr_a, addr_b, wdat_a, wdat_b, q, rsp_c, addr_c;
    logic       wstb_a, wstb_b, conflict_b, busy_b, ready_c, rval_a, rstb_a;
    int         vcnt_a = 0;
    int         scnt_a = 0;
    logic [7:0] last_a = 8'h00;
    int         wcnt_a = 0;
    int         wcnt_b = 0;
    int         num_errors = 0;
    int         cmp_count = 0;

    always #10 clk_in = ~clk_in;

    php_if link_a ();
    php_if link_b ();
    php_host #(.STYLE(php_pkg::PHP_STYLE_STROBE)) u_php_host (.clk_in(clk_in), .rst_in(rst_in),
        .bus(link_a), .req_valid_in(req_valid), .req_write_in(req_write), .req_sel_in(req_sel),
        .req_data_in(req_data), .req_ready_out(req_ready), .rsp_valid_out(rval_a),
        .rsp_data_out(rsp_data));
    php_device u_php_device (.clk_in(clk_in), .rst_in(rst_in), .bus(link_a),
        .rd_data_in(addr_a ^ 8'hA5), .reg_addr_out(addr_a), .rd_strobe_out(rstb_a),
        .wr_strobe_out(wstb_a), .wr_data_out(wdat_a), .busy_out(), .conflict_out());
    php_device u_php_device_b (.clk_in(clk_in), .rst_in(rst_in), .bus(link_b),
        .rd_data_in(addr_b ^ 8'h5A), .reg_addr_out(addr_b), .rd_strobe_out(),
        .wr_strobe_out(wstb_b), .wr_data_out(wdat_b), .busy_out(busy_b),
        .conflict_out(conflict_b));
    // select-strobed processor end, fed the same requests as the strobe-timed one
    php_if link_c ();
    php_host #(.STYLE(php_pkg::PHP_STYLE_SELECT)) u_php_host_c (.clk_in(clk_in),
        .rst_in(rst_in), .bus(link_c), .req_valid_in(req_valid), .req_write_in(req_write),
        .req_sel_in(req_sel), .req_data_in(req_data), .req_ready_out(ready_c),
        .rsp_valid_out(), .rsp_data_out(rsp_c));
    php_device u_php_device_c (.clk_in(clk_in), .rst_in(rst_in), .bus(link_c),
        .rd_data_in(addr_c ^ 8'hA5), .reg_addr_out(addr_c), .rd_strobe_out(),
        .wr_strobe_out(), .wr_data_out(), .busy_out(), .conflict_out());
    php_port_checker u_php_port_checker (.clk_in(clk_in), .rst_in(rst_in),
        .port_select_n(link_a.port_select_n), .port_read_strobe_n(link_a.port_read_strobe_n),
        .port_write_strobe_n(link_a.port_write_strobe_n),
        .register_select(link_a.register_select), .host_data(link_a.host_data),
        .host_data_oe_n(link_a.host_data_oe_n), .dev_data(link_a.dev_data),
        .dev_data_oe_n(link_a.dev_data_oe_n), .port_data_bus(link_a.port_data_bus));

    always @(posedge clk_in) begin
        if (wstb_a === 1'b1) begin
            wcnt_a++;
            last_a = wdat_a;
        end
        if (wstb_b === 1'b1) wcnt_b++;
        if (rval_a === 1'b1) vcnt_a++;
        if (rstb_a === 1'b1) scnt_a++;
    end

    // ======================================================
    // shared tasks
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // user request on the processor end, held until the ready pulse
    task automatic hacc(input logic w, input logic s, input logic [7:0] d);
        int n;
        n = 0;
        req_write = w;
        req_sel = s;
        req_data = d;
        req_valid = 1'b1;
        @(negedge clk_in);
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        req_valid = 1'b0;
        chk("host ready", 8'h01, 8'(req_ready));
        chk("select ready", 8'h01, 8'(ready_c));
        @(negedge clk_in);
    endtask

    // pin-level access on the second link; sty 1 times it by select
    task automatic pacc(input logic sty, input logic w, input logic s, input logic [7:0] d,
                        output logic [7:0] r);
        link_b.register_select = s;
        link_b.host_data = d;
        link_b.host_data_oe_n = !w;
        if (sty) {link_b.port_write_strobe_n, link_b.port_read_strobe_n} = {!w, w};
        else link_b.port_select_n = 1'b0;
        @(negedge clk_in);
        if (sty) link_b.port_select_n = 1'b0;
        else {link_b.port_write_strobe_n, link_b.port_read_strobe_n} = {!w, w};
        repeat (3) @(negedge clk_in);
        r = link_b.port_data_bus;
        chk("style busy", 8'h01, 8'(busy_b));
        if (sty) link_b.port_select_n = 1'b1;
        else {link_b.port_write_strobe_n, link_b.port_read_strobe_n} = 2'b11;
        repeat (3) @(negedge clk_in);
        {link_b.port_select_n, link_b.port_write_strobe_n, link_b.port_read_strobe_n} = 3'b111;
        link_b.host_data_oe_n = 1'b1;
        repeat (2) @(negedge clk_in);
    endtask

    // ======================================================
    // scenarios
    task automatic s_host_strobe();
        int c;
        hacc(1'b1, php_pkg::SEL_ADDR, 8'h3C);
        chk("reg addr", 8'h3C, addr_a);
        chk("select style addr", 8'h3C, addr_c);
        hacc(1'b0, php_pkg::SEL_ADDR, 8'h00);
        chk("addr readback", 8'h3C, rsp_data);
        chk("select style readback", 8'h3C, rsp_c);
        hacc(1'b0, php_pkg::SEL_DATA, 8'h00);
        chk("data read", 8'h3C ^ 8'hA5, rsp_data);
        chk("select style read", 8'h3C ^ 8'hA5, rsp_c);
        c = wcnt_a;
        hacc(1'b1, php_pkg::SEL_DATA, 8'hC3);
        chk("write count", 8'(c + 1), 8'(wcnt_a));
        chk("write data", 8'hC3, last_a);
        chk("addr kept", 8'h3C, addr_a);
        hacc(1'b1, php_pkg::SEL_ADDR, 8'hFF);
        hacc(1'b0, php_pkg::SEL_DATA, 8'h00);
        chk("data read top", 8'hFF ^ 8'hA5, rsp_data);
        chk("read answers", 8'h03, 8'(vcnt_a));
        chk("data reg reads", 8'h02, 8'(scnt_a));
    endtask

    task automatic s_styles();
        logic [7:0] a;
        int c;
        for (int sty = 0; sty < 2; sty++) begin
            a = 8'h81 + 8'(sty);
            pacc(sty[0], 1'b1, php_pkg::SEL_ADDR, a, q);
            chk("style addr", a, addr_b);
            pacc(sty[0], 1'b0, php_pkg::SEL_DATA, 8'h00, q);
            chk("style read", a ^ 8'h5A, q);
            c = wcnt_b;
            pacc(sty[0], 1'b1, php_pkg::SEL_DATA, 8'h66, q);
            chk("style write", 8'(c + 1), 8'(wcnt_b));
            chk("style wdata", 8'h66, wdat_b);
        end
    endtask

    // strobes with select high, then both strobes low while selected
    task automatic s_ignore();
        logic [7:0] a;
        int c;
        a = addr_b;
        c = wcnt_b;
        link_b.register_select = php_pkg::SEL_ADDR;
        link_b.host_data = ~a;
        link_b.host_data_oe_n = 1'b0;
        link_b.port_write_strobe_n = 1'b0;
        repeat (4) @(negedge clk_in);
        {link_b.port_write_strobe_n, link_b.port_read_strobe_n} = 2'b10;
        link_b.host_data_oe_n = 1'b1;
        repeat (3) @(negedge clk_in);
        chk("unselected oe", 8'h01, 8'(link_b.dev_data_oe_n));
        {link_b.port_select_n, link_b.port_write_strobe_n} = 2'b00;
        repeat (3) @(negedge clk_in);
        chk("conflict", 8'h01, 8'(conflict_b));
        chk("conflict oe", 8'h01, 8'(link_b.dev_data_oe_n));
        chk("conflict busy", 8'h00, 8'(busy_b));
        {link_b.port_select_n, link_b.port_write_strobe_n, link_b.port_read_strobe_n} = 3'b111;
        repeat (3) @(negedge clk_in);
        chk("ignored addr", a, addr_b);
        chk("ignored writes", 8'(c), 8'(wcnt_b));
    endtask

    // ======================================================
    // main sequence and watchdog
    initial begin
        {link_b.port_select_n, link_b.port_read_strobe_n, link_b.port_write_strobe_n} = 3'b111;
        link_b.register_select = 1'b0;
        link_b.host_data = 8'h00;
        link_b.host_data_oe_n = 1'b1;
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
        s_host_strobe();
        s_styles();
        s_ignore();
        close_out();
    end

    initial begin
        #100000;
        num_errors++;
        $display("[ERR] watchdog expected done seen running");
        close_out();
    end
endmodule
